// ### src/vo2c_cfg.svh
// Purpose: Offsets, field positions, reset values and fill codes
// Assumes: 32-bit register words on byte addresses
// Notes: Definitions only
`ifndef VO2C_CFG_SVH
`define VO2C_CFG_SVH
`define VO2C_OFS_CTRL  8'h00
`define VO2C_OFS_COMP  8'h04
`define VO2C_OFS_STAT  8'h08
`define VO2C_OFS_MASK  8'h0C
`define VO2C_OFS_ANCH  8'h10
`define VO2C_OFS_ANCV  8'h14
`define VO2C_OFS_LBASE 8'h18
`define VO2C_OFS_CBASE 8'h1C
`define VO2C_OFS_ABASE 8'h20
`define VO2C_OFS_PITCH 8'h24
`define VO2C_B_EN      0
`define VO2C_B_MUX     3
`define VO2C_B_FMT     4
`define VO2C_B_INT     6
`define VO2C_B_HANC    8
`define VO2C_B_CEN     0
`define VO2C_B_CMUX    3
`define VO2C_B_SIZE    16
`define VO2C_INT_TOP   2'h0
`define VO2C_INT_BOT   2'h1
`define VO2C_INT_BOTH  2'h2
`define VO2C_RST_MUX   1'b1
`define VO2C_RST_CMUX  1'b1
`define VO2C_RST_PITCH 16'h05A0
`define VO2C_FIELD_OFS 32'h0008_0000
`define VO2C_FILL_Y    8'h10
`define VO2C_FILL_C    8'h80
`define VO2C_RESP_OK   2'h0
`define VO2C_RESP_ERR  2'h2
`endif

// ### src/vo2c_pkg.sv
// Purpose: Types shared by the channel 2 control block
// Assumes: Nothing
// Notes: State of each module is one packed struct, apart from the rs_q reset synchroniser in vo2c_top
package vo2c_pkg;
   typedef enum logic [2:0] {
      RUN_IDLE = 3'b001,
      RUN_WAIT = 3'b010,
      RUN_ON   = 3'b100
   } vo2c_run_t;
   typedef enum logic [1:0] {
      KIND_LUMA   = 2'h0,
      KIND_CHROMA = 2'h1,
      KIND_ANC    = 2'h2
   } vo2c_kind_t;
   typedef struct packed {
      logic [31:0] lbase;
      logic [31:0] cbase;
      logic [31:0] abase;
      logic [15:0] pitch;
      logic [11:0] ah_start;
      logic [11:0] ah_size;
      logic [11:0] av_start;
      logic [11:0] av_size;
      logic        horiz_ancillary_insert_enable;
      logic [1:0]  frame_interrupt_source_select;
      logic        captured_field_id;
      logic        luma_address_format;
      logic        luma_chroma_interleave_select;
      logic        output_channel_enable;
      logic        companion_channel_enable;
      logic        companion_interleave_select;
      logic [1:0]  stat;
      logic [1:0]  mask;
      vo2c_run_t   run;
      logic        s1_valid;
      logic        s1_fill;
      logic [7:0]  s1_fill_val;
      logic        mem_rd;
      vo2c_kind_t  kind;
      logic [31:0] mem_addr;
      logic [7:0]  vdata;
      logic        vdata_valid;
   } vo2c_st_t;
   typedef struct packed {
      logic        aw_have;
      logic        w_have;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } vo2c_ax_t;
endpackage

// ### src/vo2c_addr.sv
// Purpose: Byte address of one sample in a memory plane
// Assumes: Sub-picture keeps each field in its own half
// Notes: Raster when i_sub is low
`timescale 1ns/1ns
`include "vo2c_cfg.svh"
module vo2c_addr #(
   parameter int AW = 32,
   parameter int LW = 12,
   parameter int PW = 16
) (
   input  wire logic [AW-1:0] i_base,
   input  wire logic [PW-1:0] i_pitch,
   input  wire logic [LW-1:0] i_line,
   input  wire logic [LW-1:0] i_col,
   input  wire logic          i_sub,
   output logic      [AW-1:0] o_addr
);
   logic [LW-1:0]    row;
   logic [AW-1:0]    fofs;
   logic [PW+LW-1:0] prod;

   always_comb begin
      row  = i_line;
      fofs = '0;
      if (i_sub) begin
         row  = i_line >> 1;
         fofs = i_line[0] ? AW'(`VO2C_FIELD_OFS) : '0;
      end
      prod   = i_pitch * row;
      o_addr = i_base + fofs + AW'(prod) + AW'(i_col);
   end
endmodule // vo2c_addr

// ### src/vo2c_axil.sv
// Purpose: AXI4-Lite slave turning transfers into register strobes
// Assumes: One write and one read under way at most
// Notes: Unmapped addresses answer with error
`timescale 1ns/1ns
`include "vo2c_cfg.svh"
module vo2c_axil (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic      [1:0]  o_bresp,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic      [31:0] o_rdata,
   output logic      [1:0]  o_rresp,
   output logic             o_wr,
   output logic      [7:0]  o_wr_addr,
   output logic      [31:0] o_wr_data,
   output logic      [3:0]  o_wr_strb,
   input  wire logic        i_wr_ok,
   output logic             o_rd,
   output logic      [7:0]  o_rd_addr,
   input  wire logic [31:0] i_rd_data,
   input  wire logic        i_rd_ok
);
   import vo2c_pkg::*;
   vo2c_ax_t q, d;

   assign o_awready = !q.aw_have && !q.bvalid;
   assign o_wready  = !q.w_have && !q.bvalid;
   assign o_arready = !q.rvalid;
   assign o_wr      = q.aw_have && q.w_have && !q.bvalid;
   assign o_wr_addr = q.awaddr;
   assign o_wr_data = q.wdata;
   assign o_wr_strb = q.wstrb;
   assign o_rd      = i_arvalid && !q.rvalid;
   assign o_rd_addr = i_araddr;
   assign o_bvalid  = q.bvalid;
   assign o_bresp   = q.bresp;
   assign o_rvalid  = q.rvalid;
   assign o_rdata   = q.rdata;
   assign o_rresp   = q.rresp;

   always_comb begin
      d = q;
      if (i_awvalid && o_awready) begin
         d.aw_have = 1'b1;
         d.awaddr  = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         d.w_have = 1'b1;
         d.wdata  = i_wdata;
         d.wstrb  = i_wstrb;
      end
      if (o_wr) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = i_wr_ok ? `VO2C_RESP_OK : `VO2C_RESP_ERR;
      end
      if (q.bvalid && i_bready) begin
         d.bvalid = 1'b0;
      end
      if (o_rd) begin
         d.rvalid = 1'b1;
         d.rdata  = i_rd_ok ? i_rd_data : 32'h0000_0000;
         d.rresp  = i_rd_ok ? `VO2C_RESP_OK : `VO2C_RESP_ERR;
      end
      if (q.rvalid && i_rready) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // vo2c_axil

// ### src/vo2c_top.sv
// Purpose: Channel 2 video output control, ancillary insert, field irq
// Assumes: Timing inputs synchronous to i_clk; memory answers same cycle
// Notes: Output bytes appear two clocks after the timing inputs
// Behaviour
// - Ancillary enable fetches ancillary bytes into blanking inside window.
// - Blanking outside the ancillary window carries 10h at odd hcount, 80h at even hcount, in both interleave modes.
// - Interrupt select: 0 top, 1 bottom, 2 both fields, 3 none.
// - Field id bit captures current field only at an interrupt event.
// - Address format bit: 0 raster, 1 sub-picture, luma data only.
// - Sub-picture luma addressing only in standard-definition mode.
// - Chroma and ancillary data always use raster addressing.
// - Interleave bit 1 puts luma and chroma in one byte stream.
// - Interleave bit 0 makes this stream chroma only.
// - Separate mode runs only when both channel enables are set.
// - Separate mode forces companion interleave bit to 1.
// - Channel enable starts output at the next vsync when 1, stops it when 0.
`timescale 1ns/1ns
`include "vo2c_cfg.svh"
module vo2c_top (
   input  wire logic                i_clk,
   input  wire logic                i_reset_n,
   input  wire logic                i_awvalid,
   output logic                     o_awready,
   input  wire logic [7:0]          i_awaddr,
   input  wire logic                i_wvalid,
   output logic                     o_wready,
   input  wire logic [31:0]         i_wdata,
   input  wire logic [3:0]          i_wstrb,
   output logic                     o_bvalid,
   input  wire logic                i_bready,
   output logic      [1:0]          o_bresp,
   input  wire logic                i_arvalid,
   output logic                     o_arready,
   input  wire logic [7:0]          i_araddr,
   output logic                     o_rvalid,
   input  wire logic                i_rready,
   output logic      [31:0]         o_rdata,
   output logic      [1:0]          o_rresp,
   input  wire logic                i_sd_mode,
   input  wire logic                i_vsync,
   input  wire logic                i_field,
   input  wire logic                i_pix_valid,
   input  wire logic                i_hblank,
   input  wire logic [11:0]         i_hcount,
   input  wire logic [11:0]         i_vcount,
   output logic                     o_mem_rd,
   output logic      [31:0]         o_mem_addr,
   output vo2c_pkg::vo2c_kind_t     o_mem_kind,
   input  wire logic [7:0]          i_mem_rdata,
   output logic      [7:0]          o_vdata,
   output logic                     o_vdata_valid,
   output logic                     o_companion_interleave,
   output logic                     o_irq
);
   import vo2c_pkg::*;

   logic [1:0]  rs_q;
   logic        rst_n;
   vo2c_st_t    st_q;
   vo2c_st_t    st_d;
   logic        wr;
   logic        rd;
   logic [7:0]  wr_addr;
   logic [7:0]  rd_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [31:0] rd_data;
   logic [31:0] ctrl_w;
   logic [31:0] comp_w;
   logic [31:0] a_luma;
   logic [31:0] a_chroma;
   logic [31:0] a_anc;
   logic [11:0] col;
   logic [11:0] a_col;
   logic [11:0] a_line;
   logic        start_ok;
   logic        frame_ev;
   logic        block_ev;
   logic        anc_hit;
   logic        fill;
   logic        luma_sub;
   vo2c_kind_t  kind;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      case (a)
         `VO2C_OFS_CTRL, `VO2C_OFS_COMP, `VO2C_OFS_STAT, `VO2C_OFS_MASK,
         `VO2C_OFS_ANCH, `VO2C_OFS_ANCV, `VO2C_OFS_LBASE, `VO2C_OFS_CBASE,
         `VO2C_OFS_ABASE, `VO2C_OFS_PITCH: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // Reset release
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rs_q <= 2'h0;
      end else begin
         rs_q <= {rs_q[0], 1'b1};
      end
   end
   assign rst_n = rs_q[1];

   vo2c_axil u_axil (
      .i_clk     (i_clk),
      .i_rst_n   (rst_n),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_awaddr  (i_awaddr),
      .i_wvalid  (i_wvalid),
      .o_wready  (o_wready),
      .i_wdata   (i_wdata),
      .i_wstrb   (i_wstrb),
      .o_bvalid  (o_bvalid),
      .i_bready  (i_bready),
      .o_bresp   (o_bresp),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .i_araddr  (i_araddr),
      .o_rvalid  (o_rvalid),
      .i_rready  (i_rready),
      .o_rdata   (o_rdata),
      .o_rresp   (o_rresp),
      .o_wr      (wr),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data),
      .o_wr_strb (wr_strb),
      .i_wr_ok   (mapped(wr_addr)),
      .o_rd      (rd),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_ok   (mapped(rd_addr))
   );

   assign ctrl_w = {23'h0, st_q.horiz_ancillary_insert_enable,
                    st_q.frame_interrupt_source_select, st_q.captured_field_id,
                    st_q.luma_address_format, st_q.luma_chroma_interleave_select,
                    2'h0, st_q.output_channel_enable};
   assign comp_w = {28'h0, st_q.companion_interleave_select, 2'h0,
                    st_q.companion_channel_enable};

   // Register read mux
   always_comb begin
      case (rd_addr)
         `VO2C_OFS_CTRL:  rd_data = ctrl_w;
         `VO2C_OFS_COMP:  rd_data = comp_w;
         `VO2C_OFS_STAT:  rd_data = {30'h0, st_q.stat};
         `VO2C_OFS_MASK:  rd_data = {30'h0, st_q.mask};
         `VO2C_OFS_ANCH:  rd_data = {4'h0, st_q.ah_size, 4'h0, st_q.ah_start};
         `VO2C_OFS_ANCV:  rd_data = {4'h0, st_q.av_size, 4'h0, st_q.av_start};
         `VO2C_OFS_LBASE: rd_data = st_q.lbase;
         `VO2C_OFS_CBASE: rd_data = st_q.cbase;
         `VO2C_OFS_ABASE: rd_data = st_q.abase;
         `VO2C_OFS_PITCH: rd_data = {16'h0, st_q.pitch};
         default:         rd_data = 32'h0000_0000;
      endcase
   end

   assign luma_sub = st_q.luma_address_format && i_sd_mode;
   assign col      = st_q.luma_chroma_interleave_select ? {1'b0, i_hcount[11:1]} : i_hcount;
   assign a_col    = i_hcount - st_q.ah_start;
   assign a_line   = i_vcount - st_q.av_start;

   vo2c_addr u_luma (
      .i_base  (st_q.lbase),
      .i_pitch (st_q.pitch),
      .i_line  (i_vcount),
      .i_col   (col),
      .i_sub   (luma_sub),
      .o_addr  (a_luma)
   );
   vo2c_addr u_chroma (
      .i_base  (st_q.cbase),
      .i_pitch (st_q.pitch),
      .i_line  (i_vcount),
      .i_col   (col),
      .i_sub   (1'b0),
      .o_addr  (a_chroma)
   );
   vo2c_addr u_anc (
      .i_base  (st_q.abase),
      .i_pitch (st_q.pitch),
      .i_line  (a_line),
      .i_col   (a_col),
      .i_sub   (1'b0),
      .o_addr  (a_anc)
   );

   always_comb begin
      logic [31:0] w;
      w  = 32'h0000_0000;
      st_d = st_q;
      start_ok = st_q.output_channel_enable &&
                 (st_q.luma_chroma_interleave_select || st_q.companion_channel_enable);
      case (st_q.frame_interrupt_source_select)
         `VO2C_INT_TOP:  frame_ev = i_vsync && !i_field;
         `VO2C_INT_BOT:  frame_ev = i_vsync && i_field;
         `VO2C_INT_BOTH: frame_ev = i_vsync;
         default:        frame_ev = 1'b0;
      endcase
      block_ev = i_vsync && st_q.output_channel_enable && !start_ok;
      if (wr) begin
         case (wr_addr)
            `VO2C_OFS_CTRL: begin
               w = merge(ctrl_w, wr_data, wr_strb);
               st_d.output_channel_enable         = w[`VO2C_B_EN];
               st_d.luma_chroma_interleave_select = w[`VO2C_B_MUX];
               st_d.luma_address_format           = w[`VO2C_B_FMT];
               st_d.frame_interrupt_source_select = w[`VO2C_B_INT +: 2];
               st_d.horiz_ancillary_insert_enable = w[`VO2C_B_HANC];
            end
            `VO2C_OFS_COMP: begin
               w = merge(comp_w, wr_data, wr_strb);
               st_d.companion_channel_enable    = w[`VO2C_B_CEN];
               st_d.companion_interleave_select = w[`VO2C_B_CMUX];
            end
            `VO2C_OFS_MASK: begin
               w = merge({30'h0, st_q.mask}, wr_data, wr_strb);
               st_d.mask = w[1:0];
            end
            `VO2C_OFS_ANCH: begin
               w = merge({4'h0, st_q.ah_size, 4'h0, st_q.ah_start}, wr_data, wr_strb);
               st_d.ah_start = w[11:0];
               st_d.ah_size  = w[`VO2C_B_SIZE +: 12];
            end
            `VO2C_OFS_ANCV: begin
               w = merge({4'h0, st_q.av_size, 4'h0, st_q.av_start}, wr_data, wr_strb);
               st_d.av_start = w[11:0];
               st_d.av_size  = w[`VO2C_B_SIZE +: 12];
            end
            `VO2C_OFS_LBASE: st_d.lbase = merge(st_q.lbase, wr_data, wr_strb);
            `VO2C_OFS_CBASE: st_d.cbase = merge(st_q.cbase, wr_data, wr_strb);
            `VO2C_OFS_ABASE: st_d.abase = merge(st_q.abase, wr_data, wr_strb);
            `VO2C_OFS_PITCH: begin
               w = merge({16'h0, st_q.pitch}, wr_data, wr_strb);
               st_d.pitch = w[15:0];
            end
            default: st_d.mask = st_q.mask;
         endcase
      end
      if (!st_d.luma_chroma_interleave_select) begin
         st_d.companion_interleave_select = 1'b1;
      end
      if (frame_ev) begin
         st_d.captured_field_id = i_field;
      end
      // Sticky status, read clears, set wins
      st_d.stat = ((rd && rd_addr == `VO2C_OFS_STAT) ? 2'h0 : st_q.stat) |
                  {block_ev, frame_ev};
      case (st_q.run)
         RUN_IDLE: if (start_ok) st_d.run = RUN_WAIT;
         RUN_WAIT: begin
            if (!start_ok) begin
               st_d.run = RUN_IDLE;
            end else if (i_vsync) begin
               st_d.run = RUN_ON;
            end
         end
         RUN_ON:   if (!start_ok) st_d.run = RUN_IDLE;
         default:  st_d.run = RUN_IDLE;
      endcase
      anc_hit = i_hblank && st_q.horiz_ancillary_insert_enable &&
                i_hcount >= st_q.ah_start && a_col < st_q.ah_size &&
                i_vcount >= st_q.av_start && a_line < st_q.av_size;
      fill = i_hblank && !anc_hit;
      if (anc_hit) begin
         kind = KIND_ANC;
      end else if (st_q.luma_chroma_interleave_select && i_hcount[0]) begin
         kind = KIND_LUMA;
      end else begin
         kind = KIND_CHROMA;
      end
      st_d.s1_valid    = st_q.run == RUN_ON && i_pix_valid;
      st_d.s1_fill     = fill;
      st_d.s1_fill_val = i_hcount[0] ? `VO2C_FILL_Y : `VO2C_FILL_C;
      st_d.mem_rd      = st_d.s1_valid && !fill;
      st_d.kind        = kind;
      case (kind)
         KIND_LUMA: st_d.mem_addr = a_luma;
         KIND_ANC:  st_d.mem_addr = a_anc;
         default:   st_d.mem_addr = a_chroma;
      endcase
      st_d.vdata_valid = st_q.s1_valid;
      if (st_q.s1_valid) begin
         st_d.vdata = st_q.s1_fill ? st_q.s1_fill_val : i_mem_rdata;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q                               <= '0;
         st_q.run                           <= RUN_IDLE;
         st_q.kind                          <= KIND_LUMA;
         st_q.luma_chroma_interleave_select <= `VO2C_RST_MUX;
         st_q.companion_interleave_select   <= `VO2C_RST_CMUX;
         st_q.pitch                         <= `VO2C_RST_PITCH;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_mem_rd               = st_q.mem_rd;
   assign o_mem_addr             = st_q.mem_addr;
   assign o_mem_kind             = st_q.kind;
   assign o_vdata                = st_q.vdata;
   assign o_vdata_valid          = st_q.vdata_valid;
   assign o_companion_interleave = st_q.companion_interleave_select;
   assign o_irq                  = |(st_q.stat & st_q.mask);

   // Checks
   logic [27:0] prod_v;
   logic [31:0] exp_l;
   logic [31:0] exp_c;
   assign prod_v = st_q.pitch * i_vcount;
   assign exp_l  = st_q.lbase + 32'(prod_v) + 32'(col);
   assign exp_c  = st_q.cbase + 32'(prod_v) + 32'(col);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fill_in;
      st_q.run == RUN_ON && i_pix_valid && fill;
   endsequence
   sequence s_fill_out;
      ##2 o_vdata_valid && o_vdata == ($past(i_hcount[0], 2) ? `VO2C_FILL_Y : `VO2C_FILL_C);
   endsequence

   property p_anc_off;
      o_mem_rd && o_mem_kind == KIND_ANC |-> $past(st_q.horiz_ancillary_insert_enable);
   endproperty
   a_anc_off: assert property (p_anc_off) else $error("ancillary read while disabled");
   property p_fill;
      s_fill_in |-> s_fill_out;
   endproperty
   a_fill: assert property (p_fill) else $error("blanking fill value wrong");
   property p_int_top;
      i_vsync && !i_field && st_q.frame_interrupt_source_select == `VO2C_INT_TOP
         |=> st_q.stat[0] && st_q.captured_field_id == 1'b0;
   endproperty
   a_int_top: assert property (p_int_top) else $error("top field event lost");
   property p_int_rsv;
      st_q.frame_interrupt_source_select == 2'h3 && !st_q.stat[0] |=> !st_q.stat[0];
   endproperty
   a_int_rsv: assert property (p_int_rsv) else $error("reserved select raised event");
   property p_fid_hold;
      !frame_ev |=> $stable(st_q.captured_field_id);
   endproperty
   a_fid_hold: assert property (p_fid_hold) else $error("field id moved without event");
   property p_luma_raster;
      o_mem_rd && o_mem_kind == KIND_LUMA && !$past(i_sd_mode) |-> o_mem_addr == $past(exp_l);
   endproperty
   a_luma_raster: assert property (p_luma_raster) else $error("HD luma not raster");
   property p_chroma_raster;
      o_mem_rd && o_mem_kind == KIND_CHROMA |-> o_mem_addr == $past(exp_c);
   endproperty
   a_chroma_raster: assert property (p_chroma_raster) else $error("chroma not raster");
   property p_sep_chroma;
      o_mem_rd && !$past(st_q.luma_chroma_interleave_select) |-> o_mem_kind != KIND_LUMA;
   endproperty
   a_sep_chroma: assert property (p_sep_chroma) else $error("luma in separate stream");
   property p_need_both;
      !start_ok |=> st_q.run == RUN_IDLE;
   endproperty
   a_need_both: assert property (p_need_both) else $error("ran without both enables");
   property p_force_cmux;
      !st_q.luma_chroma_interleave_select |-> o_companion_interleave;
   endproperty
   a_force_cmux: assert property (p_force_cmux) else $error("companion not forced");
   property p_en_off;
      $fell(st_q.output_channel_enable) |-> ##[2:3] !o_vdata_valid;
   endproperty
   a_en_off: assert property (p_en_off) else $error("output kept after disable");
endmodule // vo2c_top

// ### tb/vo2c_mem_model.sv
// Purpose: Memory seen by the channel
// Assumes: Read data in the read cycle
// Notes: Inverted pattern when idle
`timescale 1ns/1ns
module vo2c_mem_model (
   input  wire logic        i_rd,
   input  wire logic [31:0] i_addr,
   output logic      [7:0]  o_rdata
);
   // Byte derived from address
   assign o_rdata = i_rd ? (i_addr[7:0] ^ 8'h5A) : ~(i_addr[7:0] ^ 8'h5A);
endmodule // vo2c_mem_model

// ### tb/tb_vo2c_top.sv
// Purpose: Bench for channel 2 control
// Assumes: Memory model answers in the read cycle
// Notes: Random lines and columns, fixed seed
`timescale 1ns/1ns
`include "vo2c_cfg.svh"
module tb_vo2c_top;
   import vo2c_pkg::*;
   logic i_clk = 0, i_reset_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   logic i_arvalid = 0, i_rready = 0, i_sd_mode = 0, i_vsync = 0, i_field = 0;
   logic i_pix_valid = 0, i_hblank = 0, o_awready, o_wready, o_bvalid, o_arready;
   logic o_rvalid, o_mem_rd, o_vdata_valid, o_companion_interleave, o_irq, fid, q;
   logic [7:0] i_awaddr = 0, i_araddr = 0, i_mem_rdata, o_vdata;
   logic [31:0] i_wdata = 0, o_rdata, o_mem_addr, d;
   logic [3:0] i_wstrb = 4'hF;
   logic [11:0] i_hcount = 0, i_vcount = 0, h, v;
   logic [1:0] o_bresp, o_rresp, rs;
   vo2c_kind_t o_mem_kind;
   int err_count = 0, n_tests = 0, c, f;
   always #4 i_clk = ~i_clk;
   vo2c_top vo2c_top_inst (.i_clk, .i_reset_n, .i_awvalid, .o_awready, .i_awaddr,
      .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
      .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
      .i_sd_mode, .i_vsync, .i_field, .i_pix_valid, .i_hblank, .i_hcount, .i_vcount,
      .o_mem_rd, .o_mem_addr, .o_mem_kind, .i_mem_rdata, .o_vdata, .o_vdata_valid,
      .o_companion_interleave, .o_irq);
   vo2c_mem_model vo2c_mem_model_inst (.i_rd(o_mem_rd), .i_addr(o_mem_addr),
      .o_rdata(i_mem_rdata));
   task automatic stop_test();
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] mb(input logic [31:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      logic ao, wo, bo;
      logic [1:0] br;
      int k;
      i_awaddr <= a;
      i_wdata <= dd;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(negedge i_clk);
         ao = o_awready;
         wo = o_wready;
         bo = o_bvalid;
         br = o_bresp;
         @(posedge i_clk);
         if (ao) i_awvalid <= 1'b0;
         if (wo) i_wvalid <= 1'b0;
         if (bo) break;
      end
      if (k == 50) begin
         err_count++;
         stop_test();
      end
      i_bready <= 1'b0;
      chk(32'(br), 32'(`VO2C_RESP_OK));
      @(posedge i_clk);
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
      logic ao, bo;
      int k;
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(negedge i_clk);
         ao = o_arready;
         bo = o_rvalid;
         dd = o_rdata;
         rr = o_rresp;
         @(posedge i_clk);
         if (ao) i_arvalid <= 1'b0;
         if (bo) break;
      end
      if (k == 50) begin
         err_count++;
         stop_test();
      end
      i_rready <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic vs(input logic fl, output logic irq);
      i_vsync <= 1'b1;
      i_field <= fl;
      @(posedge i_clk);
      i_vsync <= 1'b0;
      @(posedge i_clk);
      @(negedge i_clk);
      irq = o_irq;
      @(posedge i_clk);
   endtask
   task automatic pix(input logic [11:0] hh, vv, input logic hb, erd,
                      input logic [31:0] ea, input logic [7:0] ev, input logic evv);
      i_pix_valid <= 1'b1;
      i_hcount <= hh;
      i_vcount <= vv;
      i_hblank <= hb;
      @(posedge i_clk);
      i_pix_valid <= 1'b0;
      @(negedge i_clk);
      chk(32'(o_mem_rd), 32'(erd));
      if (erd) chk(o_mem_addr, ea);
      if (erd) chk(32'(o_mem_kind), hb ? 32'(KIND_ANC) :
                   32'(hh[0] ? KIND_LUMA : KIND_CHROMA));
      @(negedge i_clk);
      chk(32'(o_vdata_valid), 32'(evv));
      if (evv) chk(32'(o_vdata), 32'(ev));
      @(posedge i_clk);
   endtask
   initial begin
      void'($urandom(32'h2BA7));
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rdr(`VO2C_OFS_CTRL, d, rs);
      chk(d, 32'h8);
      rdr(8'h40, d, rs);
      chk({d[29:0], rs}, 32'h2);
      wr(`VO2C_OFS_MASK, 32'h1);
      fid = 1'b0;
      for (c = 0; c < 4; c++) begin
         wr(`VO2C_OFS_CTRL, 32'(c << 6) | 32'h9);
         for (f = 0; f < 2; f++) begin
            rdr(`VO2C_OFS_STAT, d, rs);
            vs(f[0], q);
            chk(32'(q), 32'(c == 2 || c == f));
            rdr(`VO2C_OFS_STAT, d, rs);
            chk(32'(d[0]), 32'(c == 2 || c == f));
            if (c == 2 || c == f) fid = f[0];
            rdr(`VO2C_OFS_CTRL, d, rs);
            chk(32'(d[5]), 32'(fid));
         end
      end
      wr(`VO2C_OFS_CTRL, 32'h9);
      wr(`VO2C_OFS_LBASE, 32'h1000);
      repeat (8) begin
         h = 12'($urandom % 700) | 12'h1;
         v = 12'($urandom % 500);
         d = 32'h1000 + v * 32'h5A0 + h / 2;
         pix(h, v, 1'b0, 1'b1, d, mb(d), 1'b1);
      end
      pix(12'd4, 12'd2, 1'b1, 1'b0, 0, 8'h80, 1'b1);
      pix(12'd5, 12'd2, 1'b1, 1'b0, 0, 8'h10, 1'b1);
      wr(`VO2C_OFS_ANCH, 32'h0010_0000);
      wr(`VO2C_OFS_ANCV, 32'h0010_0000);
      wr(`VO2C_OFS_ABASE, 32'h2000);
      wr(`VO2C_OFS_CTRL, 32'h119);
      d = 32'h2000 + 2 * 32'h5A0 + 6;
      pix(12'd6, 12'd2, 1'b1, 1'b1, d, mb(d), 1'b1);
      pix(12'd20, 12'd2, 1'b1, 1'b0, 0, 8'h80, 1'b1);
      d = 32'h1000 + 3 * 32'h5A0 + 2;
      pix(12'd5, 12'd3, 1'b0, 1'b1, d, mb(d), 1'b1);
      i_sd_mode <= 1'b1;
      d = 32'h1000 + 32'h5A0 + 2 + 32'h8_0000;
      pix(12'd5, 12'd3, 1'b0, 1'b1, d, mb(d), 1'b1);
      wr(`VO2C_OFS_CTRL, 32'h1);
      wr(`VO2C_OFS_COMP, 32'h0);
      rdr(`VO2C_OFS_COMP, d, rs);
      chk({d[3], 30'h0, o_companion_interleave}, 32'h8000_0001);
      vs(1'b0, q);
      rdr(`VO2C_OFS_STAT, d, rs);
      chk(d, 32'h3);
      pix(12'd5, 12'd3, 1'b0, 1'b0, 0, 0, 1'b0);
      wr(`VO2C_OFS_COMP, 32'h1);
      vs(1'b0, q);
      d = 3 * 32'h5A0 + 4;
      pix(12'd4, 12'd3, 1'b0, 1'b1, d, mb(d), 1'b1);
      wr(`VO2C_OFS_CTRL, 32'h0);
      pix(12'd5, 12'd3, 1'b0, 1'b0, 0, 0, 1'b0);
      stop_test();
   end
endmodule // tb_vo2c_top
